// file: rtl/console_pkg.sv
// Constants shared by the console status logic and its bench.
// Assumes one 40 MHz clock and a synchronous, active-high reset.
package console_pkg;

    // ------------------------------------------------------------------
    // Status and sense bit positions
    // ------------------------------------------------------------------
    localparam int ST_UE = 7;
    localparam int ST_UC = 6;
    localparam int ST_DE = 5;
    localparam int ST_CE = 4;
    localparam int ST_BUSY = 3;
    localparam int ST_ATTN = 0;
    localparam int SN_CR = 0;
    localparam int SN_IR = 1;
    localparam int SN_BOC = 2;
    localparam int SN_EQC = 3;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_TIO = 8'h00;
    localparam logic [7:0] CMD_NOOP = 8'h03;
    localparam logic [7:0] CMD_SENSE = 8'h04;
    localparam logic [7:0] CMD_ALARM = 8'h0b;
    localparam logic [7:0] CMD_WR_CR = 8'h09;
    localparam logic [7:0] CMD_WR_NOCR = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h0a;

    // ------------------------------------------------------------------
    // Operation states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_IDLE = 5'b00001,
        OP_READ = 5'b00010,
        OP_WRITE = 5'b00100,
        OP_SENSE = 5'b01000,
        OP_MECH = 5'b10000
    } op_state_t;

endpackage

// file: rtl/key_if.sv
// Carrier between the console core and its key decoder.
// Raw key levels go in, one-cycle key events come out.
`timescale 1ns/1ps
interface key_if;
    logic alt_key;
    logic digit5_key;
    logic digit0_key;
    logic ready_key;
    logic notready_key;
    logic request_key;
    logic eob_evt;
    logic cancel_evt;
    logic ready_evt;
    logic notready_evt;
    logic request_evt;

    modport decoder (
        input alt_key, digit5_key, digit0_key, ready_key, notready_key,
        input request_key,
        output eob_evt, cancel_evt, ready_evt, notready_evt, request_evt
    );
    modport core (
        output alt_key, digit5_key, digit0_key, ready_key, notready_key,
        output request_key,
        input eob_evt, cancel_evt, ready_evt, notready_evt, request_evt
    );
endinterface

// file: rtl/key_decode.sv
// Console key decoder: turns key levels into one-cycle events.
// Keys are taken as synchronous levels that were debounced upstream.
`timescale 1ns/1ps
module key_decode (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Keys
    key_if.decoder keys
);
    logic [4:0] prev_reg;
    logic [4:0] now_w;
    logic [4:0] rise_w;

    // ------------------------------------------------------------------
    // Press detection
    // ------------------------------------------------------------------
    // Digit keys only count with alternate coding held
    assign now_w = {keys.alt_key & keys.digit5_key,
                    keys.alt_key & keys.digit0_key,
                    keys.ready_key, keys.notready_key, keys.request_key};
    assign rise_w = now_w & ~prev_reg;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            prev_reg <= 5'h00;
        end else begin
            prev_reg <= now_w;
        end
    end

    assign keys.eob_evt = rise_w[4];
    assign keys.cancel_evt = rise_w[3];
    assign keys.ready_evt = rise_w[2];
    assign keys.notready_evt = rise_w[1];
    assign keys.request_evt = rise_w[0];
endmodule

// file: rtl/console_status.sv
// Console control unit status and sense logic.
// Assumes channel strobes are one-cycle pulses synchronous to mclk_i.
`timescale 1ns/1ps
module console_status (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic sel_reset_i,
    // Straps
    input wire logic mode4_strap_i,
    input wire logic prio_high_strap_i,
    // Channel selection
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_parity_ok_i,
    input wire logic chaining_i,
    // Channel data and status handshakes
    input wire logic sense_xfer_i,
    input wire logic stop_i,
    input wire logic data_parity_err_i,
    input wire logic status_accept_i,
    input wire logic status_stack_i,
    // Console
    input wire logic alt_key_i,
    input wire logic digit5_key_i,
    input wire logic digit0_key_i,
    input wire logic ready_key_i,
    input wire logic notready_key_i,
    input wire logic request_key_i,
    input wire logic forms_out_i,
    input wire logic print_done_i,
    input wire logic equip_fault_i,
    // Selection answer
    output logic init_valid_o,
    output logic [7:0] init_status_o,
    output logic cmd_start_o,
    // Pending status and sense
    output logic [7:0] status_o,
    output logic status_pend_o,
    output logic [7:0] sense_o,
    // Console state
    output logic ready_o,
    output logic busy_o,
    output logic read_active_o,
    output logic write_active_o,
    output logic eob_o,
    output logic cancel_o,
    output logic mode4_o,
    output logic prio_high_o
);
    console_pkg::op_state_t state_reg;
    console_pkg::op_state_t state_next;
    logic ue_reg, uc_reg, de_reg, ce_reg, busy_reg, attn_reg;
    logic ue_next, uc_next, de_next, ce_next, busy_next, attn_next;
    logic [3:0] sense_reg;
    logic [3:0] sense_next;
    logic stacked_reg, ready_reg;
    logic init_valid_reg, cmd_start_reg, eob_reg, cancel_reg;
    logic [7:0] init_status_reg;
    logic [7:0] init_status_next;
    logic mode4_reg, prio_reg, pend_reg, rd_reg, wr_reg;

    key_if keys ();

    // ------------------------------------------------------------------
    // Key decoder
    // ------------------------------------------------------------------
    assign keys.alt_key = alt_key_i;
    assign keys.digit5_key = digit5_key_i;
    assign keys.digit0_key = digit0_key_i;
    assign keys.ready_key = ready_key_i;
    assign keys.notready_key = notready_key_i;
    assign keys.request_key = request_key_i;

    key_decode u_keys (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .keys(keys.decoder)
    );

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    function automatic logic is_rw(input logic [7:0] code);
        is_rw = (code == console_pkg::CMD_READ) ||
                (code == console_pkg::CMD_WR_CR) ||
                (code == console_pkg::CMD_WR_NOCR);
    endfunction

    function automatic logic is_ctl(input logic [7:0] code);
        is_ctl = (code == console_pkg::CMD_NOOP) ||
                 (code == console_pkg::CMD_ALARM);
    endfunction

    logic any_reset_w, idle_w, rd_w, wr_w, sn_w, mech_w;
    logic tio_w, valid_w, busy_any_w, busy_new_w, sel_w;
    logic sel_busy_w, sel_par_w, sel_rej_w, sel_ir_w, sel_ctl_w;
    logic sel_sense_w, sel_rw_w, sel_tio_w, sel_uc_w;
    logic ce_evt_w, ce_cancel_w, de_mech_w, attn_set_w, ready_set_w;
    logic ir_key_w;

    assign any_reset_w = reset_i | sel_reset_i;
    assign idle_w = state_reg == console_pkg::OP_IDLE;
    assign rd_w = state_reg == console_pkg::OP_READ;
    assign wr_w = state_reg == console_pkg::OP_WRITE;
    assign sn_w = state_reg == console_pkg::OP_SENSE;
    assign mech_w = state_reg == console_pkg::OP_MECH;
    assign tio_w = cmd_code_i == console_pkg::CMD_TIO;
    assign valid_w = is_rw(cmd_code_i) | is_ctl(cmd_code_i) | tio_w |
                     (cmd_code_i == console_pkg::CMD_SENSE);

    // Busy for every command: before CE, or after CE until DE
    assign busy_any_w = ~idle_w;
    // Busy for all but test I/O: stacked CE, pending DE or attention
    assign busy_new_w = (stacked_reg & ce_reg) | de_reg | attn_reg;

    // Selection outcomes, in priority order
    assign sel_w = cmd_valid_i & ~any_reset_w;
    assign sel_busy_w = sel_w & (busy_any_w | (~tio_w & busy_new_w));
    assign sel_tio_w = sel_w & ~sel_busy_w & tio_w;
    assign sel_par_w = sel_w & ~sel_busy_w & ~tio_w & ~cmd_parity_ok_i;
    assign sel_rej_w = sel_w & ~sel_busy_w & ~tio_w & cmd_parity_ok_i &
                       ~valid_w;
    // Not ready found while selecting a read or write
    assign sel_ir_w = sel_w & ~sel_busy_w & cmd_parity_ok_i &
                      is_rw(cmd_code_i) & ~ready_reg;
    assign sel_ctl_w = sel_w & ~sel_busy_w & cmd_parity_ok_i &
                       is_ctl(cmd_code_i);
    assign sel_sense_w = sel_w & ~sel_busy_w & cmd_parity_ok_i &
                         (cmd_code_i == console_pkg::CMD_SENSE);
    assign sel_rw_w = sel_w & ~sel_busy_w & cmd_parity_ok_i &
                      is_rw(cmd_code_i) & ready_reg;
    // Unit check answers at selection and nothing starts
    assign sel_uc_w = sel_par_w | sel_rej_w | sel_ir_w;

    // ------------------------------------------------------------------
    // Operation events
    // ------------------------------------------------------------------
    // Write ends on stop, end-of-block or cancel; read alike
    assign ce_evt_w = (rd_w | wr_w) &
                      (stop_i | keys.eob_evt | keys.cancel_evt);
    // Cancel on a read brings unit exception with CE
    assign ce_cancel_w = rd_w & keys.cancel_evt;
    // Device end waits for the printer mechanical cycle
    assign de_mech_w = mech_w & print_done_i;
    // Request key gated by busy, selection and chaining
    assign attn_set_w = keys.request_evt & ~busy_reg & ~busy_any_w &
                        ~cmd_valid_i & ~chaining_i;
    // Not ready to ready brings DE and busy
    assign ready_set_w = keys.ready_evt & ~ready_reg;
    // Not ready key or forms out while idle sets intervention only
    assign ir_key_w = (keys.notready_evt | forms_out_i) & ~busy_reg &
                      ~busy_any_w & ~cmd_valid_i;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            console_pkg::OP_IDLE: begin
                if (sel_sense_w) begin
                    state_next = console_pkg::OP_SENSE;
                end else if (sel_rw_w) begin
                    if (cmd_code_i == console_pkg::CMD_READ) begin
                        state_next = console_pkg::OP_READ;
                    end else begin
                        state_next = console_pkg::OP_WRITE;
                    end
                end
            end
            console_pkg::OP_READ, console_pkg::OP_WRITE: begin
                // CE frees the channel; the printer may still run
                if (ce_evt_w) begin
                    state_next = console_pkg::OP_MECH;
                end
            end
            console_pkg::OP_SENSE: begin
                if (sense_xfer_i) begin
                    state_next = console_pkg::OP_IDLE;
                end
            end
            console_pkg::OP_MECH: begin
                if (print_done_i) begin
                    state_next = console_pkg::OP_IDLE;
                end
            end
            default: state_next = console_pkg::OP_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Sense byte
    // ------------------------------------------------------------------
    logic sense_clr_w;
    logic [3:0] sense_set_w;
    // Clear on start of read, write or control, and on a read or write refused as not ready
    assign sense_clr_w = sel_rw_w | sel_ctl_w | sel_ir_w;
    // Selection-time, write data parity, key and CE/DE-time sense sources
    assign sense_set_w[console_pkg::SN_CR] = sel_rej_w;
    assign sense_set_w[console_pkg::SN_IR] = sel_ir_w | ir_key_w;
    assign sense_set_w[console_pkg::SN_BOC] = sel_par_w |
                                               (wr_w & data_parity_err_i);
    assign sense_set_w[console_pkg::SN_EQC] = (ce_evt_w | de_mech_w) &
                                               equip_fault_i;
    assign sense_next = (sense_clr_w ? 4'h0 : sense_reg) | sense_set_w;

    // ------------------------------------------------------------------
    // Status bits; a set in the cycle of an acceptance wins
    // ------------------------------------------------------------------
    logic uc_set_w;
    // Unit check on any sense bit but intervention, or IR on rw
    assign uc_set_w = (|sense_set_w[3:2]) | sense_set_w[console_pkg::SN_CR] |
                      sel_ir_w;

    always_comb begin
        ue_next = (ue_reg & ~status_accept_i) | ce_cancel_w;
        uc_next = (uc_reg & ~status_accept_i) | (uc_set_w & ~sel_uc_w);
        // Device end on finish of sense, print cycle or ready
        de_next = (de_reg & ~status_accept_i) | de_mech_w | ready_set_w |
                  (sn_w & sense_xfer_i);
        // Sense ends with CE and DE after its one byte
        ce_next = (ce_reg & ~status_accept_i) | ce_evt_w |
                  (sn_w & sense_xfer_i);
        attn_next = (attn_reg & ~status_accept_i) | attn_set_w;
        // Busy cleared by acceptance, set by its five causes
        busy_next = (busy_reg & ~status_accept_i) | sel_sense_w |
                    sel_rw_w | attn_set_w | ready_set_w | status_stack_i;
    end

    // ------------------------------------------------------------------
    // Initial selection status
    // ------------------------------------------------------------------
    always_comb begin
        init_status_next = console_pkg::BYTE_RESET;
        if (sel_busy_w) begin
            // Refused command sees busy, plus attention if held
            init_status_next[console_pkg::ST_BUSY] = 1'b1;
            init_status_next[console_pkg::ST_ATTN] = attn_reg;
        end else if (sel_tio_w) begin
            // Test I/O shows pending attention alone
            init_status_next[console_pkg::ST_ATTN] = attn_reg;
        end else if (sel_uc_w) begin
            init_status_next[console_pkg::ST_UC] = 1'b1;
        end else if (sel_ctl_w) begin
            // Control immediate ends at selection
            init_status_next[console_pkg::ST_CE] = 1'b1;
            init_status_next[console_pkg::ST_DE] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (any_reset_w) begin
            // Both resets drop status and operation
            state_reg <= console_pkg::OP_IDLE;
            {ue_reg, uc_reg, de_reg, ce_reg, rd_reg, wr_reg} <= 6'h00;
            {busy_reg, attn_reg, stacked_reg, pend_reg} <= 4'h0;
        end else begin
            state_reg <= state_next;
            {ue_reg, uc_reg, de_reg, ce_reg} <=
                {ue_next, uc_next, de_next, ce_next};
            {busy_reg, attn_reg} <= {busy_next, attn_next};
            stacked_reg <= (stacked_reg & ~status_accept_i) | status_stack_i;
            pend_reg <= ue_next | uc_next | de_next | ce_next | attn_next;
            rd_reg <= state_next == console_pkg::OP_READ;
            wr_reg <= state_next == console_pkg::OP_WRITE;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (any_reset_w) begin
            sense_reg <= 4'h0;
            init_valid_reg <= 1'b0;
            init_status_reg <= console_pkg::BYTE_RESET;
            cmd_start_reg <= 1'b0;
            eob_reg <= 1'b0;
            cancel_reg <= 1'b0;
        end else begin
            sense_reg <= sense_next;
            init_valid_reg <= sel_w;
            init_status_reg <= init_status_next;
            cmd_start_reg <= sel_rw_w | sel_sense_w | sel_ctl_w;
            eob_reg <= keys.eob_evt;
            cancel_reg <= keys.cancel_evt;
        end
    end

    // Ready survives a selective reset; straps are caught under reset
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ready_reg <= 1'b0;
            mode4_reg <= mode4_strap_i;
            prio_reg <= prio_high_strap_i;
        end else if (keys.notready_evt) begin
            ready_reg <= 1'b0;
        end else if (keys.ready_evt) begin
            ready_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Status byte layout sense byte layout
    assign status_o = {ue_reg, uc_reg, de_reg, ce_reg, busy_reg, 2'b00,
                       attn_reg};
    assign sense_o = {4'h0, sense_reg};
    assign init_valid_o = init_valid_reg;
    assign init_status_o = init_status_reg;
    assign cmd_start_o = cmd_start_reg;
    assign status_pend_o = pend_reg;
    assign ready_o = ready_reg;
    assign busy_o = busy_reg;
    assign read_active_o = rd_reg;
    assign write_active_o = wr_reg;
    assign eob_o = eob_reg;
    assign cancel_o = cancel_reg;
    assign mode4_o = mode4_reg;
    assign prio_high_o = prio_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i | sel_reset_i);

    sequence seq_in_mech;
        mech_w ##1 (mech_w && print_done_i);
    endsequence

    a_reset_clears: assert property (
        @(posedge mclk_i) disable iff (1'b0)
        reset_i |=> (status_o == 8'h00) && !busy_o)
        else $error("status not cleared by reset");
    a_cancel_ue: assert property (
        (rd_w && keys.cancel_evt) |=> ue_reg && ce_reg && mech_w)
        else $error("read cancel lacks unit exception");
    a_uc_blocks: assert property (
        sel_uc_w |=> init_valid_o && init_status_o[6] && !cmd_start_o &&
                     !read_active_o && !write_active_o)
        else $error("unit check did not block command");
    a_ctl_ends: assert property (
        sel_ctl_w |=> init_status_o[5:4] == 2'b11 && cmd_start_o)
        else $error("control lacks CE and DE");
    a_sense_ends: assert property (
        (sn_w && sense_xfer_i) |=> ce_reg && de_reg && idle_w)
        else $error("sense end status missing");
    a_mech_de: assert property (
        seq_in_mech |=> de_reg && idle_w)
        else $error("printer done without device end");
    a_busy_refuse: assert property (
        (cmd_valid_i && busy_any_w) |=> init_status_o[3] && !cmd_start_o)
        else $error("busy device took a command");
    a_attn_gate: assert property (
        $rose(attn_reg) |-> !$past(busy_reg) && !$past(chaining_i) &&
                            !$past(cmd_valid_i))
        else $error("attention set while busy");
    a_attn_hold: assert property (
        (attn_reg && !status_accept_i) |=> attn_reg && busy_reg)
        else $error("attention dropped before acceptance");
    a_tio_attn: assert property (
        (sel_tio_w && attn_reg) |=> init_status_o == 8'h01)
        else $error("test I/O status not attention alone");
    a_sense_clear: assert property (
        (sel_rw_w || sel_ctl_w) |=> sense_o == 8'h00)
        else $error("sense not cleared at start");
endmodule

// file: verif/chan_model.sv
// Host channel model: takes pending status after a short delay.
// Assumes the console clock; the bench opens or shuts acceptance.
`timescale 1ns/1ps
module chan_model #(
    parameter int DLY = 2
) (
    // Clock and control
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic accept_en_i,
    // Status handshake
    input wire logic status_pend_i,
    output logic status_accept_o
);
    int cnt;
    // Delay lets the bench see status first; one pulse per byte
    always_ff @(posedge mclk_i) begin
        if (reset_i || !accept_en_i || !status_pend_i || status_accept_o) begin
            cnt <= DLY;
            status_accept_o <= 1'b0;
        end else if (cnt == 0) begin
            status_accept_o <= 1'b1;
        end else begin
            cnt <= cnt - 1;
        end
    end
endmodule

// file: verif/console_unit_status_logic_tb_top.sv
// Bench for the console status logic, corner and random selections.
// Assumes the channel model accepts status when enabled.
`timescale 1ns/1ps
module console_unit_status_logic_tb_top;
    logic mclk_i = 0, reset_i = 1, sel_reset_i = 0, en = 0, p;
    logic mode4_strap_i, prio_high_strap_i, cmd_valid_i = 0;
    logic [7:0] cmd_code_i = 8'h00, init_status_o, status_o, sense_o;
    logic cmd_parity_ok_i = 1, sense_xfer_i = 0, stop_i = 0;
    logic status_accept_i, alt_key_i = 0, digit5_key_i = 0;
    logic digit0_key_i = 0, ready_key_i = 0, notready_key_i = 0;
    logic request_key_i = 0, print_done_i = 0, init_valid_o;
    logic cmd_start_o, status_pend_o, ready_o, busy_o, mode4_o, prio_high_o;
    logic [7:0] wr[2] = '{console_pkg::CMD_WR_CR, console_pkg::CMD_WR_NOCR};
    logic chaining_i = 0, status_stack_i = 0, data_parity_err_i = 0;
    logic equip_fault_i = 0;
    logic [7:0] sn = 8'h00;
    int fails = 0, cmp_count = 0;
    console_status console_status_i (
        .mclk_i, .reset_i, .sel_reset_i, .mode4_strap_i, .prio_high_strap_i,
        .cmd_valid_i, .cmd_code_i, .cmd_parity_ok_i, .chaining_i,
        .sense_xfer_i, .stop_i, .data_parity_err_i, .status_accept_i,
        .status_stack_i, .alt_key_i, .digit5_key_i, .digit0_key_i,
        .ready_key_i, .notready_key_i, .request_key_i, .forms_out_i(1'b0),
        .print_done_i, .equip_fault_i, .init_valid_o, .init_status_o,
        .cmd_start_o, .status_o, .status_pend_o, .sense_o, .ready_o, .busy_o,
        .read_active_o(), .write_active_o(), .eob_o(), .cancel_o(), .mode4_o,
        .prio_high_o);
    chan_model chan_model_i (.mclk_i, .reset_i, .accept_en_i(en),
        .status_pend_i(status_pend_o), .status_accept_o(status_accept_i));
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic tick(int n = 1);
        repeat (n) @(posedge mclk_i);
        #2;
    endtask
    task automatic chk(logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic sel(logic [7:0] code, logic par, logic [7:0] exp);
        tick();
        cmd_code_i = code;
        cmd_parity_ok_i = par;
        cmd_valid_i = 1;
        tick();
        cmd_valid_i = 0;
        chk(8'h01, {7'h00, init_valid_o});
        chk(exp, init_status_o);
    endtask
    // Bounded wait: a channel that never clears status ends the run
    task automatic take();
        en = 1;
        for (int i = 0; i < 20 && (status_pend_o | busy_o) !== 1'b0; i++)
            tick();
        en = 0;
        chk(8'h00, status_o);
        if (status_o !== 8'h00)
            end_sim();
    endtask
    task automatic end_sim();
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(62668));
        mode4_strap_i = 1'($urandom);
        prio_high_strap_i = 1'($urandom);
        tick(20);
        reset_i = 0;
        chk({6'h00, prio_high_strap_i, mode4_strap_i},
            {6'h00, prio_high_o, mode4_o});
        chk(8'h00, {ready_o, status_o[6:0]});
        ready_key_i = 1;
        tick(2);
        chk(8'h28, status_o);
        chk(8'h01, {7'h00, ready_o});
        take();
        sel(console_pkg::CMD_NOOP, 1, 8'h30);
        sel(console_pkg::CMD_ALARM, 1, 8'h30);
        repeat (6) begin
            p = 1'($urandom);
            sn |= p ? 8'h01 : 8'h04;
            sel(8'h10 + 8'($urandom_range(8'hef)), p, 8'h40);
            chk(sn, sense_o);
        end
        sel(console_pkg::CMD_NOOP, 1, 8'h30);
        chk(8'h00, sense_o);
        sel(console_pkg::CMD_READ, 1, 8'h00);
        sel(console_pkg::CMD_TIO, 1, 8'h08);
        alt_key_i = 1;
        tick();
        digit0_key_i = 1;
        tick(2);
        chk(8'h98, status_o);
        print_done_i = 1;
        tick();
        print_done_i = 0;
        tick();
        chk(8'hb8, status_o);
        take();
        for (int k = 0; k < 2; k++) begin
            alt_key_i = 0;
            digit0_key_i = 0;
            digit5_key_i = 0;
            sel(wr[k], 1, 8'h00);
            alt_key_i = k[0];
            data_parity_err_i = ~k[0];
            equip_fault_i = k[0];
            tick();
            data_parity_err_i = 0;
            stop_i = ~k[0];
            digit5_key_i = k[0];
            tick();
            stop_i = 0;
            tick();
            chk(8'h58, status_o);
            chk(k[0] ? 8'h08 : 8'h04, sense_o);
            sel_reset_i = 1;
            equip_fault_i = 0;
            tick();
            sel_reset_i = 0;
            chk(8'h00, status_o);
        end
        sel(console_pkg::CMD_SENSE, 1, 8'h00);
        chk(8'h08, status_o);
        sense_xfer_i = 1;
        tick();
        sense_xfer_i = 0;
        tick();
        chk(8'h38, status_o);
        status_stack_i = 1;
        tick();
        status_stack_i = 0;
        sel(console_pkg::CMD_NOOP, 1, 8'h08);
        take();
        chaining_i = 1;
        request_key_i = 1;
        tick(2);
        chk(8'h00, status_o);
        chaining_i = 0;
        request_key_i = 0;
        tick();
        request_key_i = 1;
        tick(2);
        chk(8'h09, status_o);
        sel(console_pkg::CMD_NOOP, 1, 8'h09);
        sel(console_pkg::CMD_TIO, 1, 8'h01);
        chk(8'h09, status_o);
        take();
        notready_key_i = 1;
        tick(2);
        chk(8'h00, {7'h00, ready_o});
        sel(console_pkg::CMD_READ, 1, 8'h40);
        chk(8'h00, {7'h00, cmd_start_o});
        chk(8'h02, sense_o);
        end_sim();
    end
endmodule
